// >>> design/pgtm_top.sv
`timescale 1ns/1ns
// Behaviour
// - Bits 7 and 6 of the mask register keep control inputs three and six out of output one's tree when set.
// - Bits 5 and 4 do the same for output four.
// - Bits 3 and 2 do the same for output two.
// - Bits 1 and 0 do the same for output three.
// - Bit 4 of the termination register turns on the 100 ohm termination discharge.
// - With bit 5 clear an emergency shutdown holds the aux rail off for the factory duration.
// - With bit 5 set the aux rail ignores emergency shutdown and follows only its enable bit.
// - With the aux LDO in sequence and the B switches unmerged, the control acts on the second B switch.
// - Bits 4:1 of the aux register are the aux LDO voltage code.
// - Bit 0 of the aux register enables the aux rail.
module pgtm_top #(
  parameter int OFF_CYC_A = pgtm_pkg::OFF_CYC_A,
  parameter int OFF_CYC_B = pgtm_pkg::OFF_CYC_B,
  parameter int OFF_CYC_C = pgtm_pkg::OFF_CYC_C,
  parameter int OFF_CYC_D = pgtm_pkg::OFF_CYC_D
) (
  input  wire logic       clk_sys,
  input  wire logic       sys_rst,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe_n,
  input  wire logic       control_input_three,
  input  wire logic       control_input_six,
  input  wire logic       tree_good_one,
  input  wire logic       tree_good_two,
  input  wire logic       tree_good_three,
  input  wire logic       tree_good_four,
  input  wire logic [7:0] otp_pg_mask,
  input  wire logic [7:0] otp_term_disch,
  input  wire logic [7:0] otp_aux_ctrl,
  input  wire logic [1:0] otp_off_sel,
  input  wire logic       otp_target_switch,
  input  wire logic       aux_in_sequence,
  input  wire logic       switches_merged,
  input  wire logic       emergency_shutdown,
  output logic            pg_output_one,
  output logic            pg_output_two,
  output logic            pg_output_three,
  output logic            pg_output_four,
  output logic            termination_discharge_sel,
  output logic [1:0]      aux_discharge_sel,
  output logic [3:0]      aux_voltage_code,
  output logic            aux_ldo_first_on,
  output logic            load_switch_b_second_on
);
  logic [1:0] scl_sy, sda_sy, control_input_three_sy, control_input_six_sy;
  logic       scl_d, sda_d;
  always_ff @(posedge clk_sys) begin
    scl_sy  <= {scl_sy[0], scl_in};
    sda_sy  <= {sda_sy[0], sda_in};
    control_input_three_sy <= {control_input_three_sy[0], control_input_three};
    control_input_six_sy <= {control_input_six_sy[0], control_input_six};
    scl_d   <= scl_sy[1];
    sda_d   <= sda_sy[1];
  end
  wire scl_rise = scl_sy[1] & ~scl_d;
  wire scl_fall = ~scl_sy[1] & scl_d;
  wire i2c_start = scl_sy[1] & scl_d & sda_d & ~sda_sy[1];
  wire i2c_stop  = scl_sy[1] & scl_d & ~sda_d & sda_sy[1];

  function automatic logic [7:0] reg_read(input logic [7:0] a, input logic [7:0] m, input logic [7:0] t,
                                          input logic [7:0] x);
    case (a)
      pgtm_pkg::REG_PG_MASK:    reg_read = m;
      pgtm_pkg::REG_TERM_DISCH: reg_read = t;
      pgtm_pkg::REG_AUX_CTRL:   reg_read = x;
      default:                  reg_read = 8'h00;
    endcase
  endfunction

  pgtm_pkg::pgtm_state_t state, next_state, ret, next_ret;
  logic [7:0] sh, next_sh, ptr, next_ptr;
  logic [3:0] cnt, next_cnt;
  logic       drive, next_drive;
  logic [7:0] reg_pg, next_reg_pg, reg_term, next_reg_term, reg_aux, next_reg_aux;

  always_comb begin
    next_state    = state;
    next_ret      = ret;
    next_sh       = sh;
    next_ptr      = ptr;
    next_cnt      = cnt;
    next_drive    = drive;
    next_reg_pg   = reg_pg;
    next_reg_term = reg_term;
    next_reg_aux  = reg_aux;
    if (i2c_start) begin
      next_state = pgtm_pkg::PGTM_ADDR;
      next_cnt   = 4'h0;
      next_drive = 1'b0;
    end else if (i2c_stop) begin
      next_state = pgtm_pkg::PGTM_IDLE;
      next_drive = 1'b0;
    end else begin
      case (state)
        pgtm_pkg::PGTM_ADDR, pgtm_pkg::PGTM_REG, pgtm_pkg::PGTM_WR: begin
          if (scl_rise) begin
            next_sh  = {sh[6:0], sda_sy[1]};
            next_cnt = cnt + 4'h1;
          end else if (scl_fall && cnt == 4'h8) begin
            next_drive = 1'b1;
            next_state = pgtm_pkg::PGTM_ACK;
            if (state == pgtm_pkg::PGTM_ADDR) begin
              if (sh[7:1] != pgtm_pkg::I2C_DEV_ADDR) begin
                next_drive = 1'b0;
                next_state = pgtm_pkg::PGTM_IDLE;
              end
              next_ret = sh[0] ? pgtm_pkg::PGTM_RD : pgtm_pkg::PGTM_REG;
            end else if (state == pgtm_pkg::PGTM_REG) begin
              next_ptr = sh;
              next_ret = pgtm_pkg::PGTM_WR;
            end else begin
              // Reserved termination bits stored as written; host restores factory values
              case (ptr)
                pgtm_pkg::REG_PG_MASK:    next_reg_pg   = sh;
                pgtm_pkg::REG_TERM_DISCH: next_reg_term = sh;
                pgtm_pkg::REG_AUX_CTRL:   next_reg_aux  = sh;
                default:                  next_reg_pg   = reg_pg;
              endcase
              next_ret = pgtm_pkg::PGTM_WR;
            end
          end
        end
        pgtm_pkg::PGTM_ACK: begin
          if (scl_fall) begin
            next_cnt   = 4'h0;
            next_state = ret;
            next_drive = 1'b0;
            if (ret == pgtm_pkg::PGTM_RD) begin
              next_sh    = reg_read(ptr, reg_pg, reg_term, reg_aux);
              next_drive = ~next_sh[7];
            end
          end
        end
        pgtm_pkg::PGTM_RD: begin
          if (scl_rise) begin
            next_cnt = cnt + 4'h1;
          end else if (scl_fall) begin
            if (cnt == 4'h8) begin
              next_drive = 1'b0;
              next_state = pgtm_pkg::PGTM_RACK;
            end else begin
              next_sh    = {sh[6:0], 1'b0};
              next_drive = ~sh[6];
            end
          end
        end
        pgtm_pkg::PGTM_RACK: begin
          // Master nack ends the read; ack repeats the same register
          if (scl_rise && sda_sy[1]) begin
            next_state = pgtm_pkg::PGTM_IDLE;
          end else if (scl_fall) begin
            next_cnt   = 4'h0;
            next_state = pgtm_pkg::PGTM_RD;
            next_sh    = reg_read(ptr, reg_pg, reg_term, reg_aux);
            next_drive = ~next_sh[7];
          end
        end
        default: begin
          next_drive = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state    <= pgtm_pkg::PGTM_IDLE;
      ret      <= pgtm_pkg::PGTM_IDLE;
      sh       <= 8'h00;
      ptr      <= 8'h00;
      cnt      <= 4'h0;
      drive    <= 1'b0;
      reg_pg   <= otp_pg_mask;
      reg_term <= otp_term_disch;
      reg_aux  <= otp_aux_ctrl;
    end else begin
      state    <= next_state;
      ret      <= next_ret;
      sh       <= next_sh;
      ptr      <= next_ptr;
      cnt      <= next_cnt;
      drive    <= next_drive;
      reg_pg   <= next_reg_pg;
      reg_term <= next_reg_term;
      reg_aux  <= next_reg_aux;
    end
  end

  // Emergency shutdown hold-off timer, retriggers while shutdown persists
  logic [pgtm_pkg::OFF_CNT_W-1:0] off_cnt, next_off_cnt, off_len;
  always_comb begin
    case (otp_off_sel)
      2'h0:    off_len = pgtm_pkg::OFF_CNT_W'(OFF_CYC_A);
      2'h1:    off_len = pgtm_pkg::OFF_CNT_W'(OFF_CYC_B);
      2'h2:    off_len = pgtm_pkg::OFF_CNT_W'(OFF_CYC_C);
      default: off_len = pgtm_pkg::OFF_CNT_W'(OFF_CYC_D);
    endcase
    next_off_cnt = off_cnt;
    if (reg_aux[pgtm_pkg::BIT_AUX_SDWN]) begin
      next_off_cnt = '0;
    end else if (emergency_shutdown) begin
      next_off_cnt = off_len;
    end else if (off_cnt != '0) begin
      next_off_cnt = off_cnt - 1'b1;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      off_cnt <= '0;
    end else begin
      off_cnt <= next_off_cnt;
    end
  end

  logic [3:0] next_pg;
  logic       next_ldo_on, next_sw_on, target_sw, rail_on;
  always_comb begin
    next_pg[0] = tree_good_one & (reg_pg[pgtm_pkg::BIT_O1_IN3] | control_input_three_sy[1])
               & (reg_pg[pgtm_pkg::BIT_O1_IN6] | control_input_six_sy[1]);
    next_pg[1] = tree_good_two & (reg_pg[pgtm_pkg::BIT_O2_IN3] | control_input_three_sy[1])
               & (reg_pg[pgtm_pkg::BIT_O2_IN6] | control_input_six_sy[1]);
    next_pg[2] = tree_good_three & (reg_pg[pgtm_pkg::BIT_O3_IN3] | control_input_three_sy[1])
               & (reg_pg[pgtm_pkg::BIT_O3_IN6] | control_input_six_sy[1]);
    next_pg[3] = tree_good_four & (reg_pg[pgtm_pkg::BIT_O4_IN3] | control_input_three_sy[1])
               & (reg_pg[pgtm_pkg::BIT_O4_IN6] | control_input_six_sy[1]);
    target_sw   = otp_target_switch | (aux_in_sequence & ~switches_merged);
    rail_on     = reg_aux[pgtm_pkg::BIT_AUX_EN] & (next_off_cnt == '0);
    next_ldo_on = rail_on & ~target_sw;
    next_sw_on  = rail_on & target_sw;
  end
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      {pg_output_four, pg_output_three, pg_output_two, pg_output_one} <= 4'h0;
      termination_discharge_sel <= 1'b0;
      aux_discharge_sel         <= pgtm_pkg::DIS_NONE;
      aux_voltage_code          <= 4'h0;
      aux_ldo_first_on          <= 1'b0;
      load_switch_b_second_on   <= 1'b0;
      sda_out                   <= 1'b0;
      sda_oe_n                  <= 1'b1;
    end else begin
      {pg_output_four, pg_output_three, pg_output_two, pg_output_one} <= next_pg;
      termination_discharge_sel <= reg_term[pgtm_pkg::BIT_TERM_DISCH];
      aux_discharge_sel <= reg_aux[pgtm_pkg::BIT_AUX_DIS_HI:pgtm_pkg::BIT_AUX_DIS_LO];
      aux_voltage_code  <= reg_aux[pgtm_pkg::BIT_AUX_VID_HI:pgtm_pkg::BIT_AUX_VID_LO];
      aux_ldo_first_on          <= next_ldo_on;
      load_switch_b_second_on   <= next_sw_on;
      sda_out                   <= 1'b0;
      sda_oe_n                  <= ~next_drive;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  a_pg_one_tree: assert property (1'b1 |=> pg_output_one == ($past(tree_good_one)
    && ($past(reg_pg[7]) || $past(control_input_three_sy[1])) && ($past(reg_pg[6]) || $past(control_input_six_sy[1]))))
    else $error("output one tree wrong");
  a_pg_four_mask: assert property ((reg_pg[5:4] == 2'h3 && tree_good_four) |=> pg_output_four)
    else $error("output four not masked");
  a_pg_two_ctl: assert property ((!reg_pg[3] && !control_input_three_sy[1]) |=> !pg_output_two)
    else $error("output two ignores input three");
  a_pg_three_ctl: assert property ((!reg_pg[0] && !control_input_six_sy[1]) |=> !pg_output_three)
    else $error("output three ignores input six");
  a_term_disch_sel: assert property (1'b1 |=> termination_discharge_sel == $past(reg_term[4]))
    else $error("termination discharge wrong");
  a_aux_disch_sel: assert property (1'b1 |=> aux_discharge_sel == $past(reg_aux[7:6]))
    else $error("aux discharge wrong");
  a_esd_hold_off: assert property ((emergency_shutdown && !reg_aux[5]) |=>
    (!aux_ldo_first_on && !load_switch_b_second_on) [*8])
    else $error("rail on during shutdown");
  a_esd_ignored: assert property ((reg_aux[5] && reg_aux[0]) |=>
    (aux_ldo_first_on || load_switch_b_second_on))
    else $error("rail off though shutdown ignored");
  a_switch_target: assert property ((aux_in_sequence && !switches_merged) |=> !aux_ldo_first_on)
    else $error("wrong rail targeted");
  a_aux_vcode: assert property (1'b1 |=> aux_voltage_code == $past(reg_aux[4:1]))
    else $error("voltage code wrong");
  a_aux_en_off: assert property (!reg_aux[0] |=> !aux_ldo_first_on && !load_switch_b_second_on)
    else $error("rail on while disabled");
  a_reset_load: assert property (disable iff (1'b0) sys_rst |=> reg_aux == $past(otp_aux_ctrl))
    else $error("factory value not loaded");
endmodule

// >>> design/pgtm_pkg.sv
package pgtm_pkg;
  localparam logic [7:0]  REG_PG_MASK     = 8'hAC;
  localparam logic [7:0]  REG_TERM_DISCH  = 8'hAD;
  localparam logic [7:0]  REG_AUX_CTRL    = 8'hAE;
  localparam logic [6:0]  I2C_DEV_ADDR    = 7'h2A;
  localparam int          BIT_O1_IN3      = 7;
  localparam int          BIT_O1_IN6      = 6;
  localparam int          BIT_O4_IN3      = 5;
  localparam int          BIT_O4_IN6      = 4;
  localparam int          BIT_O2_IN3      = 3;
  localparam int          BIT_O2_IN6      = 2;
  localparam int          BIT_O3_IN3      = 1;
  localparam int          BIT_O3_IN6      = 0;
  localparam int          BIT_TERM_DISCH  = 4;
  localparam int          BIT_AUX_DIS_HI  = 7;
  localparam int          BIT_AUX_DIS_LO  = 6;
  localparam int          BIT_AUX_SDWN    = 5;
  localparam int          BIT_AUX_VID_HI  = 4;
  localparam int          BIT_AUX_VID_LO  = 1;
  localparam int          BIT_AUX_EN      = 0;
  localparam logic [1:0]  DIS_NONE        = 2'h0;
  localparam logic [1:0]  DIS_100_OHM     = 2'h1;
  localparam logic [1:0]  DIS_200_OHM     = 2'h2;
  localparam logic [1:0]  DIS_500_OHM     = 2'h3;
  localparam int          CLK_HZ          = 50000000;
  localparam int          OFF_MS_A        = 1;
  localparam int          OFF_MS_B        = 5;
  localparam int          OFF_MS_C        = 10;
  localparam int          OFF_MS_D        = 100;
  localparam int          OFF_CYC_A       = OFF_MS_A * (CLK_HZ / 1000);
  localparam int          OFF_CYC_B       = OFF_MS_B * (CLK_HZ / 1000);
  localparam int          OFF_CYC_C       = OFF_MS_C * (CLK_HZ / 1000);
  localparam int          OFF_CYC_D       = OFF_MS_D * (CLK_HZ / 1000);
  localparam int          OFF_CNT_W       = 24;
  typedef enum logic [2:0] {
    PGTM_IDLE = 3'b000,
    PGTM_ADDR = 3'b001,
    PGTM_REG  = 3'b010,
    PGTM_WR   = 3'b011,
    PGTM_RD   = 3'b100,
    PGTM_ACK  = 3'b101,
    PGTM_RACK = 3'b110
  } pgtm_state_t;
endpackage

// >>> dv/pgtm_host.sv
`timescale 1ns/1ns
// Open-drain host: only ever pulls SDA low, the pull-up gives the high level
module pgtm_host (
  input  wire logic       clk_sys,
  input  wire logic       sda_line,
  input  wire logic [7:0] otp_term,
  output logic            scl,
  output logic            sda_pull
);
  // Phases of T clocks stay well above the 3-clock delay of the synchronisers and edge detect
  localparam int T = 10;
  int   nacks = 0;
  logic b;
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  // SDA only moves two clocks after SCL falls, never next to the edge
  task automatic pulse();
    tick(T);
    scl = 1'b1;
    tick(T);
    b = sda_line;
    scl = 1'b0;
    tick(2);
  endtask
  task automatic start();
    sda_pull = 1'b0;
    tick(T);
    scl = 1'b1;
    tick(T);
    sda_pull = 1'b1;
    tick(T);
    scl = 1'b0;
    tick(2);
  endtask
  task automatic stop();
    sda_pull = 1'b1;
    tick(T);
    scl = 1'b1;
    tick(T);
    sda_pull = 1'b0;
    tick(T);
  endtask
  task automatic send(input logic [7:0] v);
    for (int i = 7; i >= 0; i--) begin
      sda_pull = ~v[i];
      pulse();
    end
    sda_pull = 1'b0;
    pulse();
    if (b !== 1'b0) nacks++;
  endtask
  task automatic wr(input logic [6:0] da, input logic [7:0] r, input logic [7:0] d);
    start();
    send({da, 1'b0});
    send(r);
    send((r === pgtm_pkg::REG_TERM_DISCH) ? ((d & 8'h10) | (otp_term & 8'hEF)) : d);
    stop();
  endtask
  task automatic rd(input logic [6:0] da, input logic [7:0] r, output logic [7:0] d);
    start();
    send({da, 1'b0});
    send(r);
    start();
    send({da, 1'b1});
    for (int i = 7; i >= 0; i--) begin
      sda_pull = 1'b0;
      pulse();
      d[i] = b;
    end
    // Released line is the closing not-acknowledge
    sda_pull = 1'b0;
    pulse();
    stop();
  endtask
endmodule

// >>> dv/test_pg_tree_mask_and_rail_ctrl.sv
`timescale 1ns/1ns
module test_pg_tree_mask_and_rail_ctrl;
  logic clk_sys = 1'b0, sys_rst = 1'b1, control_input_three = 1'b0, control_input_six = 1'b0;
  logic tree_good_one = 1'b1, tree_good_two = 1'b1, tree_good_three = 1'b1, tree_good_four = 1'b1;
  logic [7:0] otp_pg_mask = 8'h96, otp_term_disch = 8'h5F, otp_aux_ctrl = 8'h15;
  logic [1:0] otp_off_sel = 2'h0;
  logic otp_target_switch = 1'b0, aux_in_sequence = 1'b0, switches_merged = 1'b0, emergency_shutdown = 1'b0;
  logic scl, sda_pull, sda_out, sda_oe_n, sda_line;
  logic pg_output_one, pg_output_two, pg_output_three, pg_output_four, termination_discharge_sel;
  logic [1:0] aux_discharge_sel;
  logic [3:0] aux_voltage_code;
  logic aux_ldo_first_on, load_switch_b_second_on;
  logic [7:0] rb, cur_mask;
  int n_mismatch = 0, total_checks = 0;
  // Register, data written, value read back, {discharge, code, rail, termination}
  logic [31:0] rows [11] = '{32'hAD004F2A, 32'hAD105F2B, 32'hAE434347, 32'hAE808081, 32'hAEDFDFFF,
    32'hAE202001, 32'hACFFFF01, 32'hAC000001, 32'hACA5A501, 32'hAC5A5A01, 32'hB5770001};
  assign sda_line = ~sda_pull & (sda_oe_n | sda_out);
  initial forever #10 clk_sys = ~clk_sys;
  pgtm_top #(.OFF_CYC_A(10), .OFF_CYC_B(20), .OFF_CYC_C(30), .OFF_CYC_D(40)) u_pgtm_top (
    .clk_sys, .sys_rst, .scl_in(scl), .sda_in(sda_line), .sda_out, .sda_oe_n,
    .control_input_three, .control_input_six, .tree_good_one, .tree_good_two, .tree_good_three,
    .tree_good_four, .otp_pg_mask, .otp_term_disch, .otp_aux_ctrl, .otp_off_sel, .otp_target_switch,
    .aux_in_sequence, .switches_merged, .emergency_shutdown, .pg_output_one, .pg_output_two,
    .pg_output_three, .pg_output_four, .termination_discharge_sel, .aux_discharge_sel,
    .aux_voltage_code, .aux_ldo_first_on, .load_switch_b_second_on);
  pgtm_host u_pgtm_host (.clk_sys, .sda_line, .otp_term(otp_term_disch), .scl, .sda_pull);
  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  function automatic logic [7:0] obs();
    return {aux_discharge_sel, aux_voltage_code, aux_ldo_first_on, termination_discharge_sel};
  endfunction
  // Each output gated by its own pair of mask bits, tree members all good
  task automatic pg_sweep(input logic [7:0] m);
    for (int c = 0; c < 4; c++) begin
      control_input_three = c[0];
      control_input_six = c[1];
      tick(8);
      chk("pg", {4'h0, (m[7] | c[0]) & (m[6] | c[1]), (m[3] | c[0]) & (m[2] | c[1]),
        (m[1] | c[0]) & (m[0] | c[1]), (m[5] | c[0]) & (m[4] | c[1])},
        {4'h0, pg_output_one, pg_output_two, pg_output_three, pg_output_four});
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (80000) @(posedge clk_sys);
    n_mismatch++;
    summarize();
  end
  initial begin
    tick(20);
    sys_rst = 1'b0;
    tick(5);
    u_pgtm_host.rd(pgtm_pkg::I2C_DEV_ADDR, pgtm_pkg::REG_PG_MASK, rb);
    chk("mask reset", otp_pg_mask, rb);
    u_pgtm_host.rd(pgtm_pkg::I2C_DEV_ADDR, pgtm_pkg::REG_TERM_DISCH, rb);
    chk("term reset", otp_term_disch, rb);
    u_pgtm_host.rd(pgtm_pkg::I2C_DEV_ADDR, pgtm_pkg::REG_AUX_CTRL, rb);
    chk("aux reset", otp_aux_ctrl, rb);
    chk("outputs reset", 8'h2B, obs());
    $display("reset test done");
    cur_mask = otp_pg_mask;
    for (int r = 0; r < 11; r++) begin
      u_pgtm_host.wr(pgtm_pkg::I2C_DEV_ADDR, rows[r][31:24], rows[r][23:16]);
      tick(5);
      u_pgtm_host.rd(pgtm_pkg::I2C_DEV_ADDR, rows[r][31:24], rb);
      chk("readback", rows[r][15:8], rb);
      chk("outputs", rows[r][7:0], obs());
      if (rows[r][31:24] === pgtm_pkg::REG_PG_MASK) cur_mask = rows[r][23:16];
      pg_sweep(cur_mask);
    end
    $display("row test done");
    {tree_good_one, tree_good_two, tree_good_three, tree_good_four} = 4'h0;
    tick(4);
    chk("pg bad tree", 8'h00, {4'h0, pg_output_one, pg_output_two, pg_output_three, pg_output_four});
    {tree_good_one, tree_good_two, tree_good_three, tree_good_four} = 4'hF;
    u_pgtm_host.wr(7'h2B, pgtm_pkg::REG_PG_MASK, 8'h00);
    u_pgtm_host.rd(pgtm_pkg::I2C_DEV_ADDR, pgtm_pkg::REG_PG_MASK, rb);
    chk("foreign address", cur_mask, rb);
    chk("nacks", 8'h03, u_pgtm_host.nacks[7:0]);
    $display("tree and address test done");
    u_pgtm_host.wr(pgtm_pkg::I2C_DEV_ADDR, pgtm_pkg::REG_AUX_CTRL, 8'h01);
    for (int s = 0; s < 4; s++) begin
      otp_off_sel = s[1:0];
      emergency_shutdown = 1'b1;
      tick(2);
      chk("rail in shutdown", 8'h00, {7'h0, aux_ldo_first_on});
      emergency_shutdown = 1'b0;
      tick(10 * (s + 1) - 3);
      chk("rail held off", 8'h00, {7'h0, aux_ldo_first_on});
      tick(6);
      chk("rail back on", 8'h01, {7'h0, aux_ldo_first_on});
    end
    u_pgtm_host.wr(pgtm_pkg::I2C_DEV_ADDR, pgtm_pkg::REG_AUX_CTRL, 8'h21);
    emergency_shutdown = 1'b1;
    tick(4);
    chk("rail ignores shutdown", 8'h01, {7'h0, aux_ldo_first_on});
    emergency_shutdown = 1'b0;
    aux_in_sequence = 1'b1;
    tick(4);
    chk("rail target", 8'h01, {6'h0, aux_ldo_first_on, load_switch_b_second_on});
    switches_merged = 1'b1;
    tick(4);
    chk("rail target merged", 8'h02, {6'h0, aux_ldo_first_on, load_switch_b_second_on});
    otp_target_switch = 1'b1;
    tick(4);
    chk("rail target factory", 8'h01, {6'h0, aux_ldo_first_on, load_switch_b_second_on});
    otp_target_switch = 1'b0;
    $display("shutdown and target test done");
    // Mid-run reset must reload the factory values over host writes
    sys_rst = 1'b1;
    tick(3);
    sys_rst = 1'b0;
    tick(5);
    chk("outputs after reset", 8'h2B, obs());
    u_pgtm_host.rd(pgtm_pkg::I2C_DEV_ADDR, pgtm_pkg::REG_PG_MASK, rb);
    chk("mask reload", otp_pg_mask, rb);
    u_pgtm_host.rd(pgtm_pkg::I2C_DEV_ADDR, pgtm_pkg::REG_AUX_CTRL, rb);
    chk("aux reload", otp_aux_ctrl, rb);
    $display("mid-run reset test done");
    summarize();
  end
endmodule
